// ==== inc/bps_pkg.sv ====
// constants, types and helpers shared by the buck protection sequencer
package bps_pkg;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned MIN_OFF_NS    = 170;
	localparam int unsigned BLANK_NS      = 100;
	localparam int unsigned CAL_NS        = 2000;
	localparam int unsigned TMR_W         = 16;
	// least times round up to whole cycles
	localparam logic [TMR_W-1:0] MIN_OFF_CYC =
		TMR_W'((MIN_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] BLANK_CYC =
		TMR_W'((BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] CAL_CYC =
		TMR_W'((CAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] TMR_RST = 16'h0000;

	// ---------------------------------------------------------------
	// fault counter
	// ---------------------------------------------------------------
	localparam int unsigned      CNT_W     = 3;
	localparam logic [CNT_W-1:0] CNT_MAX   = 3'h7;
	localparam logic [CNT_W-1:0] CNT_RST   = 3'h0;
	localparam logic [CNT_W-1:0] CNT_ONE   = 3'h1;

	// ---------------------------------------------------------------
	// short-circuit multiplier strap
	// ---------------------------------------------------------------
	localparam logic [1:0] STRAP_10K  = 2'h0;
	localparam logic [1:0] STRAP_OPEN = 2'h1;
	localparam logic [1:0] STRAP_20K  = 2'h2;
	localparam logic [3:0] MULT_LOW   = 4'h3;
	localparam logic [3:0] MULT_MID   = 4'h7;
	localparam logic [3:0] MULT_HIGH  = 4'hF;
	localparam logic [3:0] MULT_RST   = 4'h7;
	// ramp feed-forward divisor, realised in the analog timing pin
	localparam int unsigned FEEDFWD_K = 15;

	// pin filter width: all synchronised comparator and strap inputs
	localparam int unsigned PIN_W = 14;

	typedef enum logic [2:0] {
		BPS_OFF,
		BPS_CAL,
		BPS_SOFT,
		BPS_RUN,
		BPS_FAULT
	} bps_state_t;

	// strap code to multiplier value; unused code treated as open strap
	function automatic logic [3:0] bps_strap_to_mult(input logic [1:0] code);
		case (code)
			STRAP_10K:  bps_strap_to_mult = MULT_LOW;
			STRAP_OPEN: bps_strap_to_mult = MULT_MID;
			STRAP_20K:  bps_strap_to_mult = MULT_HIGH;
			default:    bps_strap_to_mult = MULT_MID;
		endcase
	endfunction : bps_strap_to_mult

	// saturating blanking timer step
	function automatic logic [TMR_W-1:0] bps_blank_step(
		input logic             run,
		input logic [TMR_W-1:0] cnt);
		if (!run)
			bps_blank_step = TMR_RST;
		else if (cnt == BLANK_CYC)
			bps_blank_step = cnt;
		else
			bps_blank_step = TMR_W'(cnt + 16'h0001);
	endfunction : bps_blank_step

endpackage : bps_pkg

// ==== inc/bps_fault_if.sv ====
// fault counter control and status between sequencer and counter
`timescale 1ns/1ps
interface bps_fault_if;
	import bps_pkg::*;
	logic             clear;
	logic             inc;
	logic             dec;
	logic             load_max;
	logic [CNT_W-1:0] count;
	logic             fault;
	modport ctrl (output clear, inc, dec, load_max, input count, fault);
	modport cnt  (input clear, inc, dec, load_max, output count, fault);
endinterface : bps_fault_if

// ==== rtl/bps_pin_filter.sv ====
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module bps_pin_filter #(
	parameter int unsigned W = 1
) (
	// clock and reset
	input  wire logic         sys_clk_in,
	input  wire logic         rst_in,
	// raw and filtered levels
	input  wire logic [W-1:0] raw_in,
	output logic      [W-1:0] clean_out
);
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;

	// stage1 is seen by stage2 only, so metastability never reaches logic
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else begin
			stage1 <= raw_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// a bit follows only once stages two and three agree
	always_ff @(posedge sys_clk_in) begin
		if (rst_in)
			clean_out <= '0;
		else
			clean_out <= (stage2 & stage3) | (clean_out & (stage2 ^ stage3));
	end

endmodule : bps_pin_filter

// ==== rtl/bps_fault_counter.sv ====
// 3-bit up/down overcurrent fault counter
`timescale 1ns/1ps
module bps_fault_counter (
	// clock and reset
	input  wire logic sys_clk_in,
	input  wire logic rst_in,
	// control and status
	bps_fault_if.cnt  f
);
	import bps_pkg::*;

	logic [CNT_W-1:0] next_count;

	// clear beats load, load beats step; ends saturate
	always_comb begin
		next_count = f.count;
		if (f.clear)
			next_count = CNT_RST;
		else if (f.load_max)
			next_count = CNT_MAX;
		else if (f.inc && f.count != CNT_MAX)
			next_count = CNT_W'(f.count + CNT_ONE);
		else if (f.dec && f.count != CNT_RST)
			next_count = CNT_W'(f.count - CNT_ONE);
	end

	// count and fault flag are both registered
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			f.count <= CNT_RST;
			f.fault <= 1'b0;
		end else begin
			f.count <= next_count;
			f.fault <= (next_count == CNT_MAX);
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	property p_inc;
		f.inc && !f.clear && !f.load_max && f.count != CNT_MAX
			|=> f.count == $past(f.count) + CNT_ONE;
	endproperty
	a_inc: assert property (p_inc) else $error("count not incremented");

	property p_dec;
		f.dec && !f.inc && !f.clear && !f.load_max && f.count != CNT_RST
			|=> f.count == $past(f.count) - CNT_ONE;
	endproperty
	a_dec: assert property (p_dec) else $error("count not decremented");

	property p_floor;
		f.dec && !f.inc && !f.load_max && f.count == CNT_RST
			|=> f.count == CNT_RST;
	endproperty
	a_floor: assert property (p_floor) else $error("count wrapped");

	property p_load;
		f.load_max && !f.clear |=> f.count == CNT_MAX && f.fault;
	endproperty
	a_load: assert property (p_load) else $error("load not seven");

endmodule : bps_fault_counter

// ==== rtl/bps_sequencer.sv ====
// buck protection sequencer: oscillator, gate drive, fault and soft-start
`timescale 1ns/1ps
module bps_sequencer (
	// clock and reset
	input  wire logic                       sys_clk_in,
	input  wire logic                       rst_in,
	// supervisory comparators
	input  wire logic                       enable_in,
	input  wire logic                       input_undervoltage_lockout_ok_in,
	input  wire logic                       gate_supply_ok_in,
	// oscillator and pwm comparators
	input  wire logic                       ramp_at_timing_in,
	input  wire logic                       pwm_cmp_in,
	// current sense comparators
	input  wire logic                       ocp_cmp_in,
	input  wire logic                       scp_cmp_in,
	input  wire logic [1:0]                 strap_sel_in,
	// soft-start and loop comparators
	input  wire logic                       ss_above_0p5_in,
	input  wire logic                       ss_below_0p3_in,
	input  wire logic                       ss_below_2p5_in,
	input  wire logic                       comp_at_valley_in,
	input  wire logic                       fb_at_ref_in,
	// gate drives and oscillator
	output logic                            high_gate_drive_out,
	output logic                            low_gate_drive_out,
	output logic                            osc_discharge_out,
	// soft-start controls
	output logic                            ss_fast_discharge_out,
	output logic                            ss_boost_out,
	output logic                            ss_charge_out,
	output logic                            ss_slow_discharge_out,
	output logic                            ocp_limit_raise_out,
	output logic                            regulate_to_ref_out,
	// fault status
	output logic                            overcurrent_fault_out,
	output logic [3:0]                      short_circuit_multiplier_out,
	output logic [bps_pkg::CNT_W-1:0]       fault_count_out
);
	import bps_pkg::*;

	// ---------------------------------------------------------------
	// input synchronisation
	// ---------------------------------------------------------------
	logic [PIN_W-1:0] pins;
	logic en_s, input_undervoltage_lockout_s, rail_s, ramp_s, pwm_s, ocp_s, scp_s;
	logic [1:0] strap_s;
	logic ss05_s, ss03_s, ss25_s, valley_s, fbref_s;

	bps_pin_filter #(.W(PIN_W)) u_pins (
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.raw_in     ({enable_in, input_undervoltage_lockout_ok_in, gate_supply_ok_in,
		              ramp_at_timing_in, pwm_cmp_in, ocp_cmp_in, scp_cmp_in,
		              strap_sel_in, ss_above_0p5_in, ss_below_0p3_in,
		              ss_below_2p5_in, comp_at_valley_in, fb_at_ref_in}),
		.clean_out  (pins)
	);

	assign {en_s, input_undervoltage_lockout_s, rail_s, ramp_s, pwm_s, ocp_s, scp_s, strap_s,
	        ss05_s, ss03_s, ss25_s, valley_s, fbref_s} = pins;

	// ---------------------------------------------------------------
	// fault counter
	// ---------------------------------------------------------------
	bps_fault_if f ();

	bps_fault_counter u_cnt (
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.f          (f)
	);

	assign fault_count_out       = f.count;
	assign overcurrent_fault_out = f.fault;

	// ---------------------------------------------------------------
	// state and shared terms
	// ---------------------------------------------------------------
	bps_state_t       state;
	logic [TMR_W-1:0] cal_cnt;
	logic [TMR_W-1:0] osc_cnt;
	logic [TMR_W-1:0] hi_blank;
	logic [TMR_W-1:0] lo_blank;
	logic             switching;
	logic             boost_done;
	logic             ocp_seen;
	logic             next_high;
	logic             power_ok;
	logic             cal_end;
	logic             cycle_start;
	logic             drive_ok;
	logic             sc_hit;
	logic             oc_hit;
	logic             trip;
	logic             restart;

	assign power_ok    = en_s && input_undervoltage_lockout_s && rail_s;
	assign cal_end     = (state == BPS_CAL) && (cal_cnt == CAL_CYC - 16'h0001);
	assign cycle_start = osc_discharge_out &&
	                     (osc_cnt == MIN_OFF_CYC - 16'h0001);
	assign drive_ok    = switching && !f.fault && power_ok;
	assign sc_hit      = high_gate_drive_out && (hi_blank == BLANK_CYC) &&
	                     scp_s;
	assign oc_hit      = low_gate_drive_out && (lo_blank == BLANK_CYC) &&
	                     ocp_s;
	// a trip in the very cycle that starts a new one still counts
	assign trip        = ocp_seen || oc_hit;
	assign restart     = (state == BPS_FAULT) && ss03_s;

	// ---------------------------------------------------------------
	// sequencing state machine
	// ---------------------------------------------------------------
	// losing enable, lockout or gate rail returns to off from anywhere
	always_ff @(posedge sys_clk_in) begin
		if (rst_in || !power_ok) begin
			state <= BPS_OFF;
		end else begin
			unique case (state)
				BPS_OFF: state <= BPS_CAL;
				BPS_CAL: if (cal_end) begin
					state <= BPS_SOFT;
				end
				BPS_SOFT: if (f.fault) begin
					state <= BPS_FAULT;
				end else if (switching && !ss25_s) begin
					state <= BPS_RUN;
				end
				BPS_RUN: if (f.fault) begin
					state <= BPS_FAULT;
				end
				BPS_FAULT: if (ss03_s) begin
					state <= BPS_SOFT;
				end
			endcase
		end
	end

	// calibration timer
	always_ff @(posedge sys_clk_in) begin
		if (rst_in || state != BPS_CAL)
			cal_cnt <= TMR_RST;
		else
			cal_cnt <= TMR_W'(cal_cnt + 16'h0001);
	end

	// strap is sampled only while calibrating; it then holds all run long
	always_ff @(posedge sys_clk_in) begin
		if (rst_in)
			short_circuit_multiplier_out <= MULT_RST;
		else if (state == BPS_CAL)
			short_circuit_multiplier_out <=
				bps_strap_to_mult(strap_s);
	end

	// ---------------------------------------------------------------
	// soft-start controls
	// ---------------------------------------------------------------
	// boost runs once per power-up, until the pin passes 0.5 V
	always_ff @(posedge sys_clk_in) begin
		if (rst_in || state == BPS_OFF || state == BPS_CAL)
			boost_done <= 1'b0;
		else if (state == BPS_SOFT && ss05_s)
			boost_done <= 1'b1;
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			ss_fast_discharge_out <= 1'b1;
			ss_boost_out          <= 1'b0;
			ss_charge_out         <= 1'b0;
			ss_slow_discharge_out <= 1'b0;
			ocp_limit_raise_out   <= 1'b0;
		end else begin
			ss_fast_discharge_out <= !power_ok || state == BPS_OFF ||
			                         state == BPS_CAL;
			ss_boost_out          <= power_ok && state == BPS_SOFT &&
			                         !boost_done && !ss05_s;
			ss_charge_out         <= power_ok && (state == BPS_SOFT ||
			                         state == BPS_RUN);
			ss_slow_discharge_out <= power_ok &&
			                         state == BPS_FAULT;
			ocp_limit_raise_out   <= power_ok && state == BPS_SOFT &&
			                         ss25_s;
		end
	end

	// reference takes over once feedback has reached it
	always_ff @(posedge sys_clk_in) begin
		if (rst_in || !(state == BPS_SOFT || state == BPS_RUN))
			regulate_to_ref_out <= 1'b0;
		else if (fbref_s)
			regulate_to_ref_out <= 1'b1;
	end

	// no switching until the amplifier output meets the ramp valley
	always_ff @(posedge sys_clk_in) begin
		if (rst_in || !(state == BPS_SOFT || state == BPS_RUN))
			switching <= 1'b0;
		else if (valley_s)
			switching <= 1'b1;
	end

	// ---------------------------------------------------------------
	// oscillator
	// ---------------------------------------------------------------
	// enable, lockout and gate rail hold the oscillator in reset
	always_ff @(posedge sys_clk_in) begin
		if (rst_in || !power_ok) begin
			osc_discharge_out <= 1'b0;
			osc_cnt           <= TMR_RST;
		end else if (osc_discharge_out) begin
			osc_discharge_out <= !cycle_start;
			osc_cnt           <= cycle_start ? TMR_RST :
			                     TMR_W'(osc_cnt + 16'h0001);
		end else if (ramp_s) begin
			osc_discharge_out <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// gate drives
	// ---------------------------------------------------------------
	// high pulse opens at cycle start and ends on pwm, ramp peak or fault
	always_comb begin
		next_high = high_gate_drive_out;
		if (!drive_ok || osc_discharge_out || ramp_s || !pwm_s)
			next_high = 1'b0;
		if (sc_hit)
			next_high = 1'b0;
		if (cycle_start && drive_ok && pwm_s && !sc_hit)
			next_high = 1'b1;
	end

	// low side waits one cycle after the high side drops: a short dead time
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			high_gate_drive_out <= 1'b0;
			low_gate_drive_out  <= 1'b0;
		end else begin
			high_gate_drive_out <= next_high;
			low_gate_drive_out  <= drive_ok && !next_high && !sc_hit &&
			                       !high_gate_drive_out;
		end
	end

	// blanking timers restart at every turn-on
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			hi_blank <= TMR_RST;
			lo_blank <= TMR_RST;
		end else begin
			hi_blank <= bps_blank_step(high_gate_drive_out, hi_blank);
			lo_blank <= bps_blank_step(low_gate_drive_out, lo_blank);
		end
	end

	// ---------------------------------------------------------------
	// fault counting
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (rst_in || cycle_start)
			ocp_seen <= 1'b0;
		else if (oc_hit)
			ocp_seen <= 1'b1;
	end

	// one step per cycle, decided at the next cycle's start
	assign f.inc      = cycle_start && switching && trip;
	assign f.dec      = cycle_start && switching && !trip;
	assign f.load_max = sc_hit;
	assign f.clear    = cal_end || restart;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	property p_fault_off;
		f.fault |=> !high_gate_drive_out && !low_gate_drive_out;
	endproperty
	a_fault_off: assert property (p_fault_off) else $error("drive in fault");

	property p_sc_kill;
		sc_hit |=> !high_gate_drive_out ##1 f.fault;
	endproperty
	a_sc_kill: assert property (p_sc_kill) else $error("high not cut");

	property p_off_time;
		$rose(osc_discharge_out) |-> !high_gate_drive_out [*8];
	endproperty
	a_off_time: assert property (p_off_time) else $error("pwm in off time");

	property p_off_len;
		$fell(osc_discharge_out) && power_ok
			|-> $past(osc_cnt) == MIN_OFF_CYC - 16'h0001;
	endproperty
	a_off_len: assert property (p_off_len) else $error("off time length");

	property p_ocp_window;
		$rose(ocp_seen) |-> $past(low_gate_drive_out) &&
			$past(lo_blank) == BLANK_CYC;
	endproperty
	a_ocp_window: assert property (p_ocp_window) else $error("ocp unblanked");

	// the high side must be on now and BLANK_CYC cycles earlier
	property p_scp_window;
		f.load_max |-> high_gate_drive_out &&
			$past(high_gate_drive_out, BLANK_CYC);
	endproperty
	a_scp_window: assert property (p_scp_window) else $error("scp unblanked");

	property p_strap_hold;
		$changed(short_circuit_multiplier_out) |-> $past(state) == BPS_CAL;
	endproperty
	a_strap_hold: assert property (p_strap_hold) else $error("strap late");

	property p_fast_dis;
		!power_ok |=> ss_fast_discharge_out && !ss_charge_out;
	endproperty
	a_fast_dis: assert property (p_fast_dis) else $error("no fast discharge");

	property p_cal_to_ss;
		cal_end && power_ok |=> state == BPS_SOFT ##1 ss_charge_out;
	endproperty
	a_cal_to_ss: assert property (p_cal_to_ss) else $error("no soft-start");

	property p_no_early_switch;
		!switching |-> !high_gate_drive_out ##1 !high_gate_drive_out;
	endproperty
	a_no_early_switch: assert property (p_no_early_switch)
		else $error("early switch");

	c_fault:   cover property (f.fault && state == BPS_FAULT);
	c_restart: cover property (restart ##1 state == BPS_SOFT);
	c_switch:  cover property ($rose(switching) ##[1:200] high_gate_drive_out);
	c_sc:      cover property (sc_hit);

endmodule : bps_sequencer

// ==== verification/bps_gate_model.sv ====
// switch-node sense model standing behind the two gate drivers
`timescale 1ns/1ps
module bps_gate_model (
	// gate commands
	input  wire logic high_gate_drive_in,
	input  wire logic low_gate_drive_in,
	// overload and short to inject
	input  wire logic overload_in,
	input  wire logic short_in,
	// sense comparator levels
	output logic      ocp_cmp_out,
	output logic      scp_cmp_out
);
	// a drop exists only while that switch conducts, so no stale trip
	assign ocp_cmp_out = low_gate_drive_in & overload_in;
	assign scp_cmp_out = high_gate_drive_in & short_in;
endmodule : bps_gate_model

// ==== verification/bps_sequencer_tb.sv ====
// self-checking bench for the buck protection sequencer
`timescale 1ns/1ps
module bps_sequencer_tb;
	import bps_pkg::*;
	// ----
	// stimulus and observation
	// ----
	logic clk, rst, en, uv, gs, ramp, pwm, ovl, sht;
	logic s05, s03, s25, vly, fb, ocp, scp;
	logic [1:0] strap;
	logic hg, lg, osc, fd, bst, chg, sd, rs, rr, oc;
	logic [3:0] mult;
	logic [CNT_W-1:0] cnt;
	int bad_count, samples_checked, n, k;
	typedef struct { logic [1:0] c; logic [3:0] m; } bps_row_t;
	bps_row_t rows [4] = '{'{STRAP_10K, MULT_LOW}, '{STRAP_OPEN, MULT_MID},
		'{STRAP_20K, MULT_HIGH}, '{2'h3, MULT_MID}};

	bps_sequencer DUT (.sys_clk_in(clk), .rst_in(rst), .enable_in(en),
		.input_undervoltage_lockout_ok_in(uv), .gate_supply_ok_in(gs), .ramp_at_timing_in(ramp),
		.pwm_cmp_in(pwm), .ocp_cmp_in(ocp), .scp_cmp_in(scp),
		.strap_sel_in(strap), .ss_above_0p5_in(s05),
		.ss_below_0p3_in(s03), .ss_below_2p5_in(s25),
		.comp_at_valley_in(vly), .fb_at_ref_in(fb),
		.high_gate_drive_out(hg), .low_gate_drive_out(lg),
		.osc_discharge_out(osc), .ss_fast_discharge_out(fd),
		.ss_boost_out(bst), .ss_charge_out(chg),
		.ss_slow_discharge_out(sd), .ocp_limit_raise_out(rs),
		.regulate_to_ref_out(rr), .overcurrent_fault_out(oc),
		.short_circuit_multiplier_out(mult), .fault_count_out(cnt));
	bps_gate_model PTR (.high_gate_drive_in(hg), .low_gate_drive_in(lg),
		.overload_in(ovl), .short_in(sht), .ocp_cmp_out(ocp),
		.scp_cmp_out(scp));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int c);
		repeat (c) @(negedge clk);
	endtask : cyc

	// one ramp period; held past the filter so a short blip is not lost
	task automatic osc_cycle;
		cyc(60);
		ramp = 1'b1;
		cyc(6);
		ramp = 1'b0;
		cyc(50);
	endtask : osc_cycle

	task automatic summarize;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize

	// ----
	// main sequence
	// ----
	initial begin
		{rst, pwm, s25} = 3'h7;
		{en, uv, gs, ramp, ovl, sht, s05, s03, vly, fb} = 10'h000;
		strap = STRAP_OPEN;
		cyc(3);
		chk(fd, 8'h01);
		chk({hg, lg}, 8'h00);
		chk({cnt, mult}, 8'h07);
		rst = 1'b0;
		// each strap read in calibration, frozen once it ends
		foreach (rows[i]) begin
			{en, uv, gs} = 3'h0;
			strap = rows[i].c;
			cyc(10);
			{en, uv, gs} = 3'h7;
			cyc(20);
			chk(fd, 8'h01);
			cyc(510);
			chk(mult, rows[i].m);
			strap = ~rows[i].c;
			cyc(10);
			chk(mult, rows[i].m);
			chk({fd, chg, bst}, 8'h03);
		end
		chk({rs, rr}, 8'h02);
		{s05, fb} = 2'h3;
		cyc(6);
		chk({bst, rr}, 8'h01);
		osc_cycle();
		chk(hg, 8'h00);
		{vly, s25} = 2'h2;
		cyc(6);
		chk(rs, 8'h00);
		osc_cycle();
		// discharge length with the high side held off
		cyc(60);
		ramp = 1'b1;
		for (k = 0; k < 10 && osc !== 1'b1; k++)
			cyc(1);
		n = 0;
		while (osc === 1'b1 && n < 100) begin
			chk(hg, 8'h00);
			n++;
			if (n == 4)
				ramp = 1'b0;
			cyc(1);
		end
		chk(8'(n), MIN_OFF_CYC[7:0]);
		chk({hg, lg, cnt}, 8'h10);
		ovl = 1'b1;
		repeat (2) osc_cycle();
		chk(cnt, 3'h2);
		ovl = 1'b0;
		osc_cycle();
		chk(cnt, 3'h1);
		ovl = 1'b1;
		repeat (6) osc_cycle();
		chk({oc, cnt}, 8'h0F);
		chk({hg, lg, sd}, 8'h01);
		ovl = 1'b0;
		s03 = 1'b1;
		cyc(8);
		chk({cnt, sd, chg}, 8'h01);
		s03 = 1'b0;
		osc_cycle();
		sht = 1'b1;
		for (k = 0; k < 60 && oc !== 1'b1; k++)
			cyc(1);
		// a missing trip is a mismatch; the run still ends in the report
		if (k == 60)
			bad_count++;
		chk({hg, cnt}, 8'h07);
		sht = 1'b0;
		gs = 1'b0;
		cyc(8);
		chk({fd, hg, lg}, 8'h04);
		summarize();
	end
endmodule : bps_sequencer_tb
